// ---- pkg/pwmev_pkg.sv ----
// constants and types for the pwm timer event, interrupt and protection block
package pwmev_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRLE = 8'h04;
    localparam logic [7:0] IDX_EVCTRLA = 8'h08;
    localparam logic [7:0] IDX_EVCTRLB = 8'h09;
    localparam logic [7:0] IDX_INTEN = 8'h0C;
    localparam logic [7:0] IDX_INTFLAG = 8'h0D;
    localparam logic [7:0] IDX_INPUTA = 8'h10;
    localparam logic [7:0] IDX_INPUTB = 8'h11;
    localparam logic [7:0] IDX_FAULTCTL = 8'h12;
    localparam logic [7:0] IDX_DLYCTL = 8'h14;
    localparam logic [7:0] IDX_DELAY_COUNT_VALUE = 8'h15;
    localparam logic [7:0] IDX_DBGCTL = 8'h1E;
    localparam logic [7:0] IDX_COMPARE_A_SET_VALUE = 8'h28;
    localparam logic [7:0] IDX_COMPARE_A_CLEAR_VALUE = 8'h2A;
    localparam logic [7:0] IDX_COMPARE_B_SET_VALUE = 8'h2C;
    localparam logic [7:0] IDX_COMPARE_B_CLEAR_VALUE = 8'h2E;
    // field positions
    localparam int BIT_CYCLE_END = 0;
    localparam int BIT_TRIG_A = 2;
    localparam int BIT_TRIG_B = 3;
    localparam int BIT_RUN_HALT = 0;
    localparam int BIT_FAULT_HALT = 2;
    localparam int BIT_EDGE = 4;
    localparam int BIT_RELEASE = 2;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_CMP = 12'h000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // delay select field values
    localparam logic [1:0] DSEL_OFF = 2'h0;
    localparam logic [1:0] DSEL_BLANK = 2'h1;
    localparam logic [1:0] DSEL_EVENT = 2'h2;
    // sleep modes
    localparam logic [1:0] SLP_STANDBY = 2'h2;
    localparam logic [1:0] SLP_PWRDOWN = 2'h3;
    // input fault modes
    localparam logic [3:0] MODE_NONE = 4'h0;
    localparam logic [3:0] MODE_JUMP_OPP_WAIT = 4'h1;
    localparam logic [3:0] MODE_EXEC_OPP_WAIT = 4'h2;
    localparam logic [3:0] MODE_OPP_WHILE = 4'h3;
    localparam logic [3:0] MODE_STOP_KEEP = 4'h4;
    localparam logic [3:0] MODE_DT_WHILE = 4'h5;
    localparam logic [3:0] MODE_JUMP_NEXT_WAIT = 4'h6;
    localparam logic [3:0] MODE_WAIT_SW = 4'h7;
    localparam logic [3:0] MODE_EDGE_JUMP = 4'h8;
    localparam logic [3:0] MODE_EDGE_KEEP = 4'h9;
    localparam logic [3:0] MODE_LEVEL_KEEP = 4'hA;
    // counter-match strobes
    typedef struct packed {
        logic aset;
        logic aclr;
        logic bset;
        logic bclr;
    } pwmev_match_t;
    // fault state of one input channel
    typedef struct packed {
        logic active;
        logic [3:0] action;
    } pwmev_fault_t;
    typedef enum logic [1:0] {
        DLY_IDLE,
        DLY_COUNT,
        DLY_FIRE
    } pwmev_dly_t;
endpackage

// ---- src/pwmev_top.sv ----
// event, interrupt, debug and protection logic of the 12-bit pwm timer
//
// Contract
// - four counter-match event outputs: compare A set, A clear, B set, B clear
// - each match strobe lasts exactly one counter clock period
// - programmable event strobe lasts exactly one synchronizer clock period
// - programmable event source selectable among all compare matches, A clear included
// - programmable event delay of 0 to 255 delay-clock cycles
// - blanking shares trigger and delay; when blanking, event is not delayed
// - count delay clocks until equal to delay count, then issue event
// - delay clock is synchronizer clock divided by the delay prescaler
// - each input channel supports level fault actions including wait for software
// - each input channel supports edge actions: stop then jump or keep frequency
// - cycle end flag set at each completed timer cycle
// - input A and input B trigger flags set on their input events
// - interrupt request while enabled and flag set, until flag cleared
// - input A and B trigger requests ORed into one request
// - runs in idle sleep, stops in standby and power-down
// - halts during debug halt unless run-while-halted is set
// - fault-on-halt makes a fault on both inputs for the whole halt in level and wait modes, a one-cycle fault in edge modes
// - fault control writes without a valid unlock are ignored
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pwmev_top
    import pwmev_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cnt_tick,
    input wire logic sync_tick,
    input wire logic [11:0] cnt_value,
    input wire logic cycle_done,
    input wire logic [1:0] in_event,
    input wire logic [1:0] sleep_mode,
    input wire logic debug_halt,
    input wire logic unlock_open,
    output pwmev_match_t match_evt,
    output logic prog_evt,
    output logic blank_active,
    output pwmev_fault_t fault_a,
    output pwmev_fault_t fault_b,
    output logic [7:0] fault_ctrl,
    output logic timer_run,
    output logic irq_cycle_end,
    output logic irq_trigger
);
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [7:0] ctrle_q, evctl_q [2], inen_q, inflag_q, inmode_q [2];
    logic [7:0] fault_ctl_q, dlyctl_q, delay_count_value_q, dbgctl_q;
    logic [11:0] cmp_aset_q, cmp_aclr_q, cmp_bset_q, cmp_bclr_q;
    pwmev_match_t match_q, hit;
    logic prog_q, blank_q, run_q, irq_c_q, irq_t_q, early_q;
    pwmev_dly_t dly_q;
    logic [7:0] dly_cnt_q;
    logic [2:0] pre_cnt_q;
    logic [1:0] ev_q, ev_eff, ev_hit, wait_q;
    pwmev_fault_t flt_q [2];
    logic acc, wr, rd_setup, run, sel_hit, dly_tick, halted;
    logic [7:0] idx;

    // true when the word address matches a register index
    function automatic logic at(input logic [7:0] a, input logic [7:0] i);
        at = (a == i);
    endfunction

    // rising or falling edge detection of one input channel
    function automatic logic detect(input logic now, input logic prev, input logic fall);
        detect = fall ? (prev & ~now) : (now & ~prev);
    endfunction

    assign idx = paddr[9:2];
    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite;
    assign rd_setup = psel & ~penable;
    assign halted = debug_halt & ~dbgctl_q[BIT_RUN_HALT];
    // sleep and debug gating of the counter domain
    assign run = ~(sleep_mode == SLP_STANDBY) & ~(sleep_mode == SLP_PWRDOWN) & ~halted;

    // apb handshake: no wait state, pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RST_WORD;
        end else begin
            pready_q <= rd_setup;
            if (rd_setup) begin
                pslverr_q <= 1'b0;
                prdata_q <= RST_WORD;
                case (1'b1)
                    at(idx, IDX_CTRLE): prdata_q[7:0] <= ctrle_q;
                    at(idx, IDX_EVCTRLA): prdata_q[7:0] <= evctl_q[0];
                    at(idx, IDX_EVCTRLB): prdata_q[7:0] <= evctl_q[1];
                    at(idx, IDX_INTEN): prdata_q[7:0] <= inen_q;
                    at(idx, IDX_INTFLAG): prdata_q[7:0] <= inflag_q;
                    at(idx, IDX_INPUTA): prdata_q[7:0] <= inmode_q[0];
                    at(idx, IDX_INPUTB): prdata_q[7:0] <= inmode_q[1];
                    at(idx, IDX_FAULTCTL): prdata_q[7:0] <= fault_ctl_q;
                    at(idx, IDX_DLYCTL): prdata_q[7:0] <= dlyctl_q;
                    at(idx, IDX_DELAY_COUNT_VALUE): prdata_q[7:0] <= delay_count_value_q;
                    at(idx, IDX_DBGCTL): prdata_q[7:0] <= dbgctl_q;
                    at(idx, IDX_COMPARE_A_SET_VALUE): prdata_q[11:0] <= cmp_aset_q;
                    at(idx, IDX_COMPARE_A_CLEAR_VALUE): prdata_q[11:0] <= cmp_aclr_q;
                    at(idx, IDX_COMPARE_B_SET_VALUE): prdata_q[11:0] <= cmp_bset_q;
                    at(idx, IDX_COMPARE_B_CLEAR_VALUE): prdata_q[11:0] <= cmp_bclr_q;
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // plain control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrle_q <= RST_BYTE;
            evctl_q[0] <= RST_BYTE;
            evctl_q[1] <= RST_BYTE;
            inen_q <= RST_BYTE;
            inmode_q[0] <= RST_BYTE;
            inmode_q[1] <= RST_BYTE;
            dlyctl_q <= RST_BYTE;
            delay_count_value_q <= RST_BYTE;
            dbgctl_q <= RST_BYTE;
            cmp_aset_q <= RST_CMP;
            cmp_aclr_q <= RST_CMP;
            cmp_bset_q <= RST_CMP;
            cmp_bclr_q <= RST_CMP;
        end else begin
            ctrle_q <= RST_BYTE;
            if (wr) begin
                if (at(idx, IDX_CTRLE)) ctrle_q <= pwdata[7:0];
                if (at(idx, IDX_EVCTRLA)) evctl_q[0] <= pwdata[7:0];
                if (at(idx, IDX_EVCTRLB)) evctl_q[1] <= pwdata[7:0];
                if (at(idx, IDX_INTEN)) inen_q <= pwdata[7:0];
                if (at(idx, IDX_INPUTA)) inmode_q[0] <= pwdata[7:0];
                if (at(idx, IDX_INPUTB)) inmode_q[1] <= pwdata[7:0];
                if (at(idx, IDX_DLYCTL)) dlyctl_q <= pwdata[7:0];
                if (at(idx, IDX_DELAY_COUNT_VALUE)) delay_count_value_q <= pwdata[7:0];
                if (at(idx, IDX_DBGCTL)) dbgctl_q <= pwdata[7:0];
                if (at(idx, IDX_COMPARE_A_SET_VALUE)) cmp_aset_q <= pwdata[11:0];
                if (at(idx, IDX_COMPARE_A_CLEAR_VALUE)) cmp_aclr_q <= pwdata[11:0];
                if (at(idx, IDX_COMPARE_B_SET_VALUE)) cmp_bset_q <= pwdata[11:0];
                if (at(idx, IDX_COMPARE_B_CLEAR_VALUE)) cmp_bclr_q <= pwdata[11:0];
            end
        end
    end

    // protected fault control, written only inside an unlock window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ctl_q <= RST_BYTE;
        end else if (wr && at(idx, IDX_FAULTCTL) && unlock_open) begin
            fault_ctl_q <= pwdata[7:0];
        end
    end

    // counter matches
    always_comb begin
        hit.aset = (cnt_value == cmp_aset_q);
        hit.aclr = (cnt_value == cmp_aclr_q);
        hit.bset = (cnt_value == cmp_bset_q);
        hit.bclr = (cnt_value == cmp_bclr_q);
    end

    // match strobes held for one counter clock period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= '0;
        end else if (cnt_tick) begin
            match_q <= run ? hit : '0;
        end
    end

    // programmable event trigger selection
    always_comb begin
        case (dlyctl_q[3:2])
            2'h0: sel_hit = hit.aset;
            2'h1: sel_hit = hit.aclr;
            2'h2: sel_hit = hit.bset;
            default: sel_hit = hit.bclr;
        endcase
    end

    // delay clock prescaler, divide by 1, 2, 4 or 8
    assign dly_tick = sync_tick & run & (pre_cnt_q == 3'((1 << dlyctl_q[5:4]) - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 3'h0;
        end else if (dly_q != DLY_COUNT) begin
            pre_cnt_q <= 3'h0;
        end else if (sync_tick && run) begin
            pre_cnt_q <= dly_tick ? 3'h0 : pre_cnt_q + 3'h1;
        end
    end

    // delay sequencer and event strobe of one synchronizer period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_q <= DLY_IDLE;
            dly_cnt_q <= RST_BYTE;
            prog_q <= 1'b0;
            blank_q <= 1'b0;
            early_q <= 1'b0;
        end else begin
            if (sync_tick) prog_q <= 1'b0;
            case (dly_q)
                DLY_IDLE: begin
                    dly_cnt_q <= RST_BYTE;
                    if (cnt_tick && run && sel_hit && dlyctl_q[1:0] == DSEL_BLANK) begin
                        dly_q <= (delay_count_value_q == RST_BYTE) ? DLY_FIRE : DLY_COUNT;
                        blank_q <= 1'b1;
                        early_q <= 1'b1;
                    end else if (cnt_tick && run && sel_hit && dlyctl_q[1:0] == DSEL_EVENT) begin
                        dly_q <= (delay_count_value_q == RST_BYTE) ? DLY_FIRE : DLY_COUNT;
                    end
                end
                DLY_COUNT: begin
                    if (dly_tick) begin
                        dly_cnt_q <= dly_cnt_q + 8'h01;
                        if (dly_cnt_q + 8'h01 == delay_count_value_q) dly_q <= DLY_FIRE;
                    end
                end
                DLY_FIRE: begin
                    if (sync_tick && run) begin
                        prog_q <= ~blank_q;
                        blank_q <= 1'b0;
                        dly_q <= DLY_IDLE;
                    end
                end
                default: dly_q <= DLY_IDLE;
            endcase
            // blanking trigger goes out undelayed
            if (sync_tick && early_q) begin
                prog_q <= 1'b1;
                early_q <= 1'b0;
            end
            if (dlyctl_q[1:0] == DSEL_OFF) begin
                blank_q <= 1'b0;
                early_q <= 1'b0;
                dly_q <= DLY_IDLE;
            end
        end
    end

    // input channels with debug fault injection and blanking
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_in
            assign ev_eff[ch] = in_event[ch] | (debug_halt & dbgctl_q[BIT_FAULT_HALT]);
            assign ev_hit[ch] = detect(ev_eff[ch], ev_q[ch], evctl_q[ch][BIT_EDGE]) & ~blank_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ev_q[ch] <= 1'b0;
                    wait_q[ch] <= 1'b0;
                    flt_q[ch] <= '0;
                end else begin
                    ev_q[ch] <= ev_eff[ch];
                    flt_q[ch].action <= inmode_q[ch][3:0];
                    case (inmode_q[ch][3:0])
                        MODE_OPP_WHILE, MODE_STOP_KEEP, MODE_DT_WHILE, MODE_LEVEL_KEEP:
                            flt_q[ch].active <= ev_eff[ch] & ~blank_q;
                        MODE_JUMP_OPP_WAIT, MODE_EXEC_OPP_WAIT, MODE_JUMP_NEXT_WAIT,
                        MODE_WAIT_SW: begin
                            if (ev_eff[ch] & ~blank_q) wait_q[ch] <= 1'b1;
                            else if (ctrle_q[BIT_RELEASE]) wait_q[ch] <= 1'b0;
                            flt_q[ch].active <= wait_q[ch] | (ev_eff[ch] & ~blank_q);
                        end
                        MODE_EDGE_JUMP, MODE_EDGE_KEEP:
                            flt_q[ch].active <= ev_hit[ch];
                        default: begin
                            wait_q[ch] <= 1'b0;
                            flt_q[ch].active <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // interrupt flags: set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inflag_q <= RST_BYTE;
        end else begin
            if (wr && at(idx, IDX_INTFLAG)) inflag_q <= inflag_q & ~pwdata[7:0];
            if (cycle_done && run) inflag_q[BIT_CYCLE_END] <= 1'b1;
            if (ev_hit[0]) inflag_q[BIT_TRIG_A] <= 1'b1;
            if (ev_hit[1]) inflag_q[BIT_TRIG_B] <= 1'b1;
        end
    end

    // interrupt requests and run status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_c_q <= 1'b0;
            irq_t_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            irq_c_q <= inen_q[BIT_CYCLE_END] & inflag_q[BIT_CYCLE_END];
            irq_t_q <= (inen_q[BIT_TRIG_A] & inflag_q[BIT_TRIG_A])
                | (inen_q[BIT_TRIG_B] & inflag_q[BIT_TRIG_B]);
            run_q <= run;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign match_evt = match_q;
    assign prog_evt = prog_q;
    assign blank_active = blank_q;
    assign fault_a = flt_q[0];
    assign fault_b = flt_q[1];
    assign fault_ctrl = fault_ctl_q;
    assign timer_run = run_q;
    assign irq_cycle_end = irq_c_q;
    assign irq_trigger = irq_t_q;
endmodule // pwmev_top
`default_nettype wire

// ---- test/pwmev_props.sv ----
// assertion checker for the pwm event block, with its bind
`timescale 1ns/1ns
`default_nettype none
module pwmev_props
    import pwmev_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic cnt_tick,
    input wire logic sync_tick,
    input wire logic [1:0] in_event,
    input wire logic [1:0] sleep_mode,
    input wire logic debug_halt,
    input wire logic unlock_open,
    input wire pwmev_match_t match_evt,
    input wire logic prog_evt,
    input wire logic blank_active,
    input wire pwmev_fault_t fault_a,
    input wire pwmev_fault_t fault_b,
    input wire logic [7:0] fault_ctrl,
    input wire logic timer_run,
    input wire logic irq_cycle_end,
    input wire logic irq_trigger
);
    logic wr_done;
    assign wr_done = psel && penable && pwrite && pready;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_match_edge;
        !$stable(match_evt) |-> $past(cnt_tick);
    endproperty
    a_match_edge: assert property (p_match_edge)
        else $error("match strobe moved off a tick");
    property p_match_stop;
        (cnt_tick && !timer_run) ##1 !timer_run |-> match_evt == 4'h0;
    endproperty
    a_match_stop: assert property (p_match_stop)
        else $error("match strobe while stopped");
    property p_prog_len;
        !$stable(prog_evt) |-> $past(sync_tick);
    endproperty
    a_prog_len: assert property (p_prog_len)
        else $error("event strobe moved off a tick");
    property p_irq_ce;
        $fell(irq_cycle_end) |-> $past(wr_done) || $past(wr_done, 2);
    endproperty
    a_irq_ce: assert property (p_irq_ce)
        else $error("cycle request dropped without a write");
    property p_irq_tr;
        $fell(irq_trigger) |-> $past(wr_done) || $past(wr_done, 2);
    endproperty
    a_irq_tr: assert property (p_irq_tr)
        else $error("trigger request dropped without a write");
    property p_run_stop;
        sleep_mode[1] |=> !timer_run;
    endproperty
    a_run_stop: assert property (p_run_stop)
        else $error("timer runs in deep sleep");
    property p_prot;
        !$stable(fault_ctrl) |-> $past(wr_done && unlock_open && paddr[9:2] == IDX_FAULTCTL);
    endproperty
    a_prot: assert property (p_prot)
        else $error("fault control changed without unlock");
    property p_edge;
        fault_b.action == MODE_EDGE_JUMP && fault_b.active |=> !fault_b.active;
    endproperty
    a_edge: assert property (p_edge)
        else $error("edge fault longer than one cycle");
    property p_level;
        fault_a.action == MODE_STOP_KEEP && $stable(fault_a.action) && !$past(debug_halt)
            |-> fault_a.active == $past(in_event[0] && !blank_active);
    endproperty
    a_level: assert property (p_level)
        else $error("level fault does not follow input");
    c_prog: cover property (prog_evt);
    c_trig: cover property (irq_trigger);
    c_halt: cover property (fault_a.active && fault_b.active);
endmodule // pwmev_props
bind pwmev_top pwmev_props pwmev_props_i (.*);
`default_nettype wire

// ---- test/pwmev_evsys.sv ----
// far-side stand-in: counter and synchronizer tick source
`timescale 1ns/1ns
`default_nettype none
module pwmev_evsys (
    input wire logic pclk,
    input wire logic presetn,
    output logic cnt_tick,
    output logic sync_tick,
    output logic [11:0] cnt_value,
    output logic cycle_done
);
    logic [1:0] div_q;
    assign sync_tick = 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            cnt_tick <= 1'b0;
            cnt_value <= 12'h000;
            cycle_done <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            cnt_tick <= (div_q == 2'h3);
            cycle_done <= cnt_tick && (cnt_value == 12'h00F);
            if (cnt_tick) begin
                cnt_value <= (cnt_value == 12'h00F) ? 12'h000 : cnt_value + 12'h001;
            end
        end
    end
endmodule // pwmev_evsys
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the pwm event block
`timescale 1ns/1ns
`default_nettype none
module tb
    import pwmev_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bl;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic cnt_tick, sync_tick, cycle_done, prog_evt, blank_active;
    logic [11:0] cnt_value;
    logic [1:0] in_event, sleep_mode;
    logic debug_halt, unlock_open, timer_run, irq_cycle_end, irq_trigger;
    logic [7:0] fault_ctrl;
    logic [3:0] mv;
    logic [2:0] obs;
    pwmev_match_t match_evt;
    pwmev_fault_t fault_a, fault_b;
    int bad_count, n_compared, d0, d;
    assign mv = match_evt;
    assign obs = {irq_trigger, irq_cycle_end, fault_b.active};
    pwmev_top pwmev_top_i (.*);
    pwmev_evsys pwmev_evsys_i (.*);
    always #10 pclk = ~pclk;
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        stop_test();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_obs(input int b);
        int n;
        n = 0;
        while (obs[b] !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300) hang();
    endtask
    task automatic run_dly(input logic [7:0] c, input logic [7:0] v, input int b);
        int n;
        sleep_mode <= 2'h2;
        apb(1'b1, IDX_DLYCTL, 32'h0);
        apb(1'b1, IDX_DELAY_COUNT_VALUE, {24'h0, v});
        apb(1'b1, IDX_DLYCTL, {24'h0, c});
        sleep_mode <= 2'h0;
        n = 0;
        while (mv[b] !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        d = 0;
        bl = 1'b0;
        while (prog_evt !== 1'b1 && d < 600) begin
            @(posedge pclk);
            bl = bl | blank_active;
            d++;
        end
        if (n >= 200 || d >= 600) hang();
    endtask
    initial begin
        pclk = 1'b0;
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        {in_event, sleep_mode, debug_halt, unlock_open} = 6'h0;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_INTFLAG, 32'h0);
        chk(rd, RST_WORD);
        apb(1'b1, 8'h03, 32'hFF);
        apb(1'b0, 8'h03, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, IDX_FAULTCTL, 32'hA5);
        apb(1'b0, IDX_FAULTCTL, 32'h0);
        chk(rd, RST_WORD);
        unlock_open <= 1'b1;
        apb(1'b1, IDX_FAULTCTL, 32'hA5);
        unlock_open <= 1'b0;
        apb(1'b0, IDX_FAULTCTL, 32'h0);
        chk({rd[23:0], fault_ctrl}, 32'hA5A5);
        $display("test registers done");
        apb(1'b1, IDX_COMPARE_A_SET_VALUE, 32'h5);
        apb(1'b1, IDX_COMPARE_A_CLEAR_VALUE, 32'h6);
        apb(1'b1, IDX_COMPARE_B_SET_VALUE, 32'h7);
        apb(1'b1, IDX_COMPARE_B_CLEAR_VALUE, 32'h9);
        run_dly(8'h02, 8'h00, 3);
        d0 = d;
        for (int t = 1; t < 4; t++) begin
            run_dly(8'(t * 4 + 2), 8'h00, 3 - t);
            chk(32'(d), 32'(d0));
        end
        run_dly(8'h02, 8'h0A, 3);
        chk(32'(d), 32'(d0 + 10));
        run_dly(8'h02, 8'hFF, 3);
        chk(32'(d), 32'(d0 + 255));
        run_dly(8'h12, 8'h03, 3);
        chk(32'(d), 32'(d0 + 6));
        run_dly(8'h01, 8'h0A, 3);
        chk(32'({d == d0, bl}), 32'h3);
        apb(1'b1, IDX_DLYCTL, 32'h0);
        $display("test events done");
        apb(1'b1, IDX_INTEN, 32'h1);
        wait_obs(1);
        sleep_mode <= 2'h2;
        apb(1'b1, IDX_INTFLAG, 32'h0);
        apb(1'b0, IDX_INTFLAG, 32'h0);
        chk({rd[30:0], timer_run}, 32'h2);
        apb(1'b1, IDX_INTFLAG, 32'h1);
        apb(1'b0, IDX_INTFLAG, 32'h0);
        chk({rd[30:0], irq_cycle_end}, 32'h0);
        sleep_mode <= 2'h1;
        apb(1'b1, IDX_INTEN, 32'h4);
        in_event[0] <= 1'b1;
        wait_obs(2);
        apb(1'b1, IDX_INTEN, 32'h8);
        apb(1'b0, IDX_INTFLAG, 32'h0);
        chk(32'({rd[3:2], irq_trigger}), 32'h2);
        in_event[1] <= 1'b1;
        wait_obs(2);
        apb(1'b0, IDX_INTFLAG, 32'h0);
        chk(rd & 32'hC, 32'hC);
        apb(1'b1, IDX_INTFLAG, 32'hC);
        apb(1'b0, IDX_INTEN, 32'h0);
        chk(32'({rd[3:0], irq_trigger, timer_run}), 32'h21);
        $display("test interrupts done");
        in_event <= 2'h0;
        for (int m = 0; m < 11; m++) begin
            apb(1'b1, IDX_INPUTA, 32'(m));
            apb(1'b1, IDX_INPUTB, 32'(m));
            repeat (2) @(posedge pclk);
            chk(32'({fault_a.action, fault_b.action}), 32'(m * 17));
        end
        apb(1'b1, IDX_INPUTA, 32'(MODE_WAIT_SW));
        in_event[0] <= 1'b1;
        apb(1'b1, IDX_INPUTB, 32'(MODE_EDGE_JUMP));
        in_event[0] <= 1'b0;
        apb(1'b0, IDX_INPUTA, 32'h0);
        chk(32'({rd[3:0], fault_a.active}), 32'hF);
        apb(1'b1, IDX_CTRLE, 32'h4);
        apb(1'b1, IDX_INPUTA, 32'(MODE_STOP_KEEP));
        chk(32'(fault_a.active), 32'h0);
        in_event <= 2'h3;
        wait_obs(0);
        apb(1'b1, IDX_INPUTB, 32'(MODE_STOP_KEEP));
        chk(32'(fault_a.active), 32'h1);
        $display("test inputs done");
        in_event <= 2'h0;
        debug_halt <= 1'b1;
        apb(1'b0, IDX_DBGCTL, 32'h0);
        chk(32'({rd[7:0], timer_run}), 32'h0);
        apb(1'b1, IDX_DBGCTL, 32'h5);
        apb(1'b0, IDX_DBGCTL, 32'h0);
        chk(32'({rd[7:0], fault_a.active, fault_b.active, timer_run}), 32'h2F);
        debug_halt <= 1'b0;
        apb(1'b0, IDX_DBGCTL, 32'h0);
        chk(32'({fault_a.active, fault_b.active}), 32'h0);
        $display("test debug done");
        stop_test();
    end
endmodule // tb
`default_nettype wire
